/* File: design/lcm_core.sv */
`timescale 1ns/1ps
module lcm_core
  import lcm_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             cmd_valid,
  input  wire lcm_cmd_t         cmd,
  output logic                  cmd_ready,
  output logic                  mem_rd,
  output logic [AW-1:0]         mem_addr,
  input  wire logic [DW-1:0]    mem_rdata,
  output logic                  mem_wr,
  output logic [DW-1:0]         mem_wdata,
  output logic                  branch_taken,
  output logic                  done,
  output logic                  int_inhibit,
  output logic                  aux_reg_pointer,
  output logic [15:0]           aux_reg_zero,
  output logic [15:0]           aux_reg_one,
  output logic [DW-1:0]         multiplicand,
  output logic [31:0]           product,
  output logic [31:0]           accum
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lcm_state_t         st_r, st_nxt;
  lcm_cmd_t           c_r, c_nxt;
  logic               ptr_r, ptr_nxt;
  logic [DW-1:0]      t_r, t_nxt;
  logic [31:0]        p_r, p_nxt;
  logic [31:0]        acc_r, acc_nxt;
  logic               rd_r, rd_nxt;
  logic               wr_r, wr_nxt;
  logic [AW-1:0]      ad_r, ad_nxt;
  logic [DW-1:0]      wd_r, wd_nxt;
  logic               bt_r, bt_nxt;
  logic               dn_r, dn_nxt;
  logic               inh_r, inh_nxt;
  logic               rdy_r, rdy_nxt;
  logic               a_ld, a_sel, a_inc, a_dec;
  logic [15:0]        a_val;
  logic [15:0]        ar0, ar1, cur;
  logic [DW-1:0]      op2;

  lcm_aux_unit u_aux (
    .mclk   (mclk),
    .rst    (rst),
    .ld     (a_ld),
    .ld_sel (a_sel),
    .ld_val (a_val),
    .inc    (a_inc),
    .dec    (a_dec),
    .sel    (ptr_r),
    .aux0   (ar0),
    .aux1   (ar1)
  );

  assign cur = ptr_r ? ar1 : ar0;

  function automatic logic uses_mem(input lcm_op_t o);
    return o == OP_ADD_INDIRECT_INC || o == OP_LOAD_MULTIPLICAND ||
           o == OP_MULTIPLY_MEMORY || o == OP_LOAD_AND_ACCUMULATE ||
           o == OP_DATA_SHIFT_MOVE || o == OP_LOAD_MOVE_ACCUMULATE;
  endfunction

  // ----------------------------------------------------------------
  // sequencer and datapath
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt  = st_r;
    c_nxt   = c_r;
    ptr_nxt = ptr_r;
    t_nxt   = t_r;
    p_nxt   = p_r;
    acc_nxt = acc_r;
    rd_nxt  = 1'b0;
    wr_nxt  = 1'b0;
    ad_nxt  = ad_r;
    wd_nxt  = wd_r;
    bt_nxt  = 1'b0;
    dn_nxt  = 1'b0;
    inh_nxt = 1'b0;
    rdy_nxt = rdy_r;
    a_ld    = 1'b0;
    a_sel   = 1'b0;
    a_val   = 16'h0000;
    a_inc   = 1'b0;
    a_dec   = 1'b0;
    op2     = mem_rdata;
    case (st_r)
      ST_IDLE:
      begin
        if (cmd_valid && rdy_r)
        begin
          c_nxt   = cmd;
          rdy_nxt = 1'b0;
          if (uses_mem(cmd.op))
          begin
            rd_nxt = 1'b1;
            // current value is the address even if this register also counts
            ad_nxt = (cmd.op == OP_ADD_INDIRECT_INC || cmd.indirect) ? cur : cmd.addr;
          end
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        dn_nxt  = 1'b1;
        rdy_nxt = 1'b1;
        st_nxt  = ST_IDLE;
        case (c_r.op)
          OP_BRANCH_IF_COUNTER_NONZERO:
          begin
            bt_nxt = cur[CNT_W-1:0] != 9'h000;
            a_dec  = 1'b1;
          end
          OP_LOAD_AUX_IMMEDIATE:
          begin
            a_ld  = 1'b1;
            a_sel = c_r.sel;
            a_val = c_r.imm;
          end
          OP_LOAD_AUX_POINTER:
            ptr_nxt = c_r.sel;
          OP_ADD_INDIRECT_INC:
          begin
            acc_nxt = acc_r + {{16{mem_rdata[15]}}, mem_rdata};
            a_inc   = 1'b1;
            ptr_nxt = c_r.sel;
          end
          OP_LOAD_MULTIPLICAND:
            t_nxt = mem_rdata;
          OP_MULTIPLY_MEMORY, OP_MULTIPLY_IMMEDIATE:
          begin
            if (c_r.op == OP_MULTIPLY_IMMEDIATE)
              op2 = {{(DW-IMM_W){c_r.imm[IMM_W-1]}}, c_r.imm[IMM_W-1:0]};
            p_nxt   = $signed(t_r) * $signed(op2);
            inh_nxt = 1'b1;
          end
          OP_PRODUCT_TO_ACCUM:
            acc_nxt = p_r;
          OP_ADD_PRODUCT_TO_ACCUM:
            acc_nxt = acc_r + p_r;
          OP_SUBTRACT_PRODUCT_FROM_ACCUM:
            acc_nxt = acc_r - p_r;
          OP_LOAD_AND_ACCUMULATE:
          begin
            t_nxt   = mem_rdata;
            acc_nxt = acc_r + p_r;
          end
          OP_DATA_SHIFT_MOVE, OP_LOAD_MOVE_ACCUMULATE:
          begin
            // the move takes one extra write beat; accumulator only on the combined op
            wr_nxt = 1'b1;
            ad_nxt = ad_r + 16'h0001;
            wd_nxt = mem_rdata;
            dn_nxt = 1'b0;
            rdy_nxt = 1'b0;
            st_nxt = ST_WRITE;
            if (c_r.op == OP_LOAD_MOVE_ACCUMULATE)
            begin
              t_nxt   = mem_rdata;
              acc_nxt = acc_r + p_r;
            end
          end
          default:
          begin
          end
        endcase
      end
      ST_WRITE:
      begin
        dn_nxt  = 1'b1;
        rdy_nxt = 1'b1;
        st_nxt  = ST_IDLE;
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r  <= ST_IDLE;
      c_r   <= '0;
      ptr_r <= 1'b0;
      t_r   <= 16'h0000;
      p_r   <= 32'h0000_0000;
      acc_r <= ACC_RST;
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      ad_r  <= 16'h0000;
      wd_r  <= 16'h0000;
      bt_r  <= 1'b0;
      dn_r  <= 1'b0;
      inh_r <= 1'b0;
      rdy_r <= 1'b1;
    end
    else
    begin
      st_r  <= st_nxt;
      c_r   <= c_nxt;
      ptr_r <= ptr_nxt;
      t_r   <= t_nxt;
      p_r   <= p_nxt;
      acc_r <= acc_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      ad_r  <= ad_nxt;
      wd_r  <= wd_nxt;
      bt_r  <= bt_nxt;
      dn_r  <= dn_nxt;
      inh_r <= inh_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready       = rdy_r;
  assign mem_rd          = rd_r;
  assign mem_addr        = ad_r;
  assign mem_wr          = wr_r;
  assign mem_wdata       = wd_r;
  assign branch_taken    = bt_r;
  assign done            = dn_r;
  assign int_inhibit     = inh_r;
  assign aux_reg_pointer = ptr_r;
  assign aux_reg_zero    = ar0;
  assign aux_reg_one     = ar1;
  assign multiplicand    = t_r;
  assign product         = p_r;
  assign accum           = acc_r;
endmodule

/* File: design/lcm_pkg.sv */
// Summary of operation
// - loop branch tests selected aux register for zero, branches if nonzero, then decrements
// - only low nine bits of aux registers count; 512 loops maximum
// - load-immediate writes an immediate into the named aux register
// - indirect add uses aux as address, increments it, then switches pointer
// - shared pointer/counter register: access uses current value, branch decrements it
// - multiplier takes two 16-bit operands giving 32-bit product register
// - load-multiplicand copies a memory word into the multiplicand register
// - memory multiply uses memory operand; immediate multiply uses instruction field
// - product transfers load, add or subtract product into accumulator
// - each multiply step is one cycle; 600 ns per multiply-accumulate
// - load-and-accumulate loads multiplicand and adds product in one cycle
// - data move copies word to next higher address, accumulator untouched
// - load-move-accumulate loads multiplicand, moves word up, adds product
// - pointer-load sets aux register pointer from the command's sel bit
// - immediate multiply takes 13-bit signed constant, sign-extended
// - no interrupt in the cycle right after a multiply
// - product register holds its value until the next multiply
package lcm_pkg;
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int DW          = 16;
  localparam int AW          = 16;
  localparam int CNT_W       = 9;
  localparam int IMM_W       = 13;
  localparam int CLK_NS      = 10;
  localparam int STEP_CYC    = 1;
  localparam int MAC_NS      = 600;
  localparam int LTA_MAC_NS  = 400;
  localparam logic [15:0] AUX_RST  = 16'h0000;
  localparam logic [31:0] ACC_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP,
    OP_BRANCH_IF_COUNTER_NONZERO,
    OP_LOAD_AUX_IMMEDIATE,
    OP_LOAD_AUX_POINTER,
    OP_ADD_INDIRECT_INC,
    OP_LOAD_MULTIPLICAND,
    OP_MULTIPLY_MEMORY,
    OP_MULTIPLY_IMMEDIATE,
    OP_PRODUCT_TO_ACCUM,
    OP_ADD_PRODUCT_TO_ACCUM,
    OP_SUBTRACT_PRODUCT_FROM_ACCUM,
    OP_LOAD_AND_ACCUMULATE,
    OP_DATA_SHIFT_MOVE,
    OP_LOAD_MOVE_ACCUMULATE
  } lcm_op_t;

  typedef struct packed {
    lcm_op_t         op;
    logic            indirect;
    logic            sel;
    logic [AW-1:0]   addr;
    logic [15:0]     imm;
  } lcm_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_WRITE
  } lcm_state_t;
endpackage

/* File: design/lcm_aux_unit.sv */
`timescale 1ns/1ps
module lcm_aux_unit
  import lcm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ld,
  input  wire logic        ld_sel,
  input  wire logic [15:0] ld_val,
  input  wire logic        inc,
  input  wire logic        dec,
  input  wire logic        sel,
  output logic [15:0]      aux0,
  output logic [15:0]      aux1
);
  logic [15:0] aux_r [2];
  logic [15:0] aux_nxt [2];

  // ----------------------------------------------------------------
  // nine-bit counting field
  // ----------------------------------------------------------------
  function automatic logic [15:0] step9(input logic [15:0] v, input logic up);
    logic [CNT_W-1:0] low;
    low = up ? v[CNT_W-1:0] + 9'h001 : v[CNT_W-1:0] - 9'h001;
    return {v[15:CNT_W], low};
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_aux
      always_comb
      begin
        aux_nxt[g] = aux_r[g];
        if (ld && ld_sel == g[0])
          aux_nxt[g] = ld_val;
        else if (sel == g[0] && (inc || dec))
          aux_nxt[g] = step9(aux_r[g], inc);
      end
      always_ff @(posedge mclk)
      begin
        if (rst)
          aux_r[g] <= AUX_RST;
        else
          aux_r[g] <= aux_nxt[g];
      end
    end
  endgenerate

  assign aux0 = aux_r[0];
  assign aux1 = aux_r[1];
endmodule

/* File: verification/lcm_core_sva.sv */
`timescale 1ns/1ps
module lcm_core_sva
  import lcm_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          cmd_valid,
  input wire lcm_cmd_t      cmd,
  input wire logic          cmd_ready,
  input wire logic          mem_rd,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic          mem_wr,
  input wire logic [DW-1:0] mem_wdata,
  input wire logic          branch_taken,
  input wire logic          done,
  input wire logic          int_inhibit,
  input wire logic          aux_reg_pointer,
  input wire logic [15:0]   aux_reg_zero,
  input wire logic [15:0]   aux_reg_one,
  input wire logic [DW-1:0] multiplicand,
  input wire logic [31:0]   product,
  input wire logic [31:0]   accum
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic        take;
  logic        mpy_take;
  logic [15:0] cur_aux;
  logic [31:0] t_ext;
  logic [31:0] imm_ext;
  assign take     = cmd_valid && cmd_ready;
  assign mpy_take = take && (cmd.op inside {OP_MULTIPLY_MEMORY, OP_MULTIPLY_IMMEDIATE});
  assign cur_aux  = aux_reg_pointer ? aux_reg_one : aux_reg_zero;
  assign t_ext    = {{16{multiplicand[15]}}, multiplicand};
  assign imm_ext  = {{19{cmd.imm[12]}}, cmd.imm[12:0]};

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_step_latency: assert property (
    take && !(cmd.op inside {OP_DATA_SHIFT_MOVE, OP_LOAD_MOVE_ACCUMULATE})
    |=> !cmd_ready && !done ##1 done) else $error("done not two cycles after take");
  chk_move_write: assert property (
    take && cmd.op == OP_DATA_SHIFT_MOVE |=> mem_rd ##1 (mem_wr && mem_wdata == $past(mem_rdata)
    && mem_addr == $past(mem_addr) + 16'h0001) ##1 done) else $error("move write wrong");
  chk_move_accum: assert property (
    take && cmd.op == OP_DATA_SHIFT_MOVE |=> $stable(accum) [*3]) else $error("move touched accum");
  chk_inhibit_mpy: assert property (
    mpy_take |=> ##1 int_inhibit) else $error("no inhibit after multiply");
  chk_product_hold: assert property (
    $changed(product) |-> $past(mpy_take, 2)) else $error("product changed without multiply");
  chk_imm_product: assert property (
    take && cmd.op == OP_MULTIPLY_IMMEDIATE
    |=> ##1 product == t_ext * $past(imm_ext, 2)) else $error("immediate product wrong");
  chk_branch_count: assert property (
    take && cmd.op == OP_BRANCH_IF_COUNTER_NONZERO |=> ##1
    (branch_taken == ($past(cur_aux[8:0], 2) != 9'h000)) && cur_aux ==
    {$past(cur_aux[15:9], 2), $past(cur_aux[8:0], 2) - 9'h001}) else $error("branch count wrong");
  chk_pointer_load: assert property (
    take && cmd.op == OP_LOAD_AUX_POINTER |=> ##1 aux_reg_pointer == $past(cmd.sel, 2))
    else $error("pointer not loaded");

  cov_branch: cover property (branch_taken);
  cov_inhibit: cover property (int_inhibit);
  cov_move: cover property (mem_wr);
endmodule

bind lcm_core lcm_core_sva i_sva (.mclk, .rst, .cmd_valid, .cmd, .cmd_ready, .mem_rd, .mem_addr,
  .mem_rdata, .mem_wr, .mem_wdata, .branch_taken, .done, .int_inhibit, .aux_reg_pointer,
  .aux_reg_zero, .aux_reg_one, .multiplicand, .product, .accum);

/* File: verification/lcm_mem_model.sv */
`timescale 1ns/1ps
module lcm_mem_model
  import lcm_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          mem_rd,
  input  wire logic [AW-1:0] mem_addr,
  output logic      [DW-1:0] mem_rdata,
  input  wire logic          mem_wr,
  input  wire logic [DW-1:0] mem_wdata
);
  // ----------------------------------------
  // storage, small on purpose
  // ----------------------------------------
  logic [DW-1:0] mem [0:255];
  logic          rd_r = 1'b0;
  logic [DW-1:0] last_r = 16'h0000;
  always @(posedge mclk)
  begin
    rd_r <= mem_rd;
    if (mem_wr)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd || rd_r)
      last_r <= mem_rdata;
  end
  // word valid only around a read; else inverted so stale data never matches
  assign mem_rdata = (mem_rd || rd_r) ? mem[mem_addr[7:0]] : ~last_r;
endmodule

/* File: verification/loop_counter_and_multiply_accumulate_test.sv */
`timescale 1ns/1ps
module loop_counter_and_multiply_accumulate_test
  import lcm_pkg::*;
;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
  logic          mclk, rst, cmd_valid, cmd_ready, mem_rd, mem_wr, done;
  logic          branch_taken, int_inhibit, aux_reg_pointer, bt_s, ii_s;
  lcm_cmd_t      cmd;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] mem_rdata, mem_wdata, multiplicand;
  logic [15:0]   aux_reg_zero, aux_reg_one;
  logic [31:0]   product, accum, acc0;
  int            err_total, cmp_count, lat;

  lcm_core i_dut (.mclk, .rst, .cmd_valid, .cmd, .cmd_ready, .mem_rd, .mem_addr, .mem_rdata,
    .mem_wr, .mem_wdata, .branch_taken, .done, .int_inhibit, .aux_reg_pointer, .aux_reg_zero,
    .aux_reg_one, .multiplicand, .product, .accum);
  lcm_mem_model i_mem (.mclk, .mem_rd, .mem_addr, .mem_rdata, .mem_wr, .mem_wdata);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic run(input lcm_op_t op, input logic ind, input logic sel,
                     input logic [15:0] addr, input logic [15:0] imm);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd       <= '{op, ind, sel, addr, imm};
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin @(posedge mclk); lat++; end while (done !== 1'b1 && lat < 8);
    bt_s = branch_taken;
    ii_s = int_inhibit;
    `CHK(lat, (op inside {OP_DATA_SHIFT_MOVE, OP_LOAD_MOVE_ACCUMULATE}) ? 3 : 2)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic loop_from(input logic [15:0] v, input int exp_n, input logic [15:0] exp_aux);
    int n;
    n = 0;
    run(OP_LOAD_AUX_IMMEDIATE, 1'b0, 1'b0, 16'h0000, v);
    do begin n++; run(OP_BRANCH_IF_COUNTER_NONZERO, 1'b0, 1'b0, 16'h0000, 16'h0000); end
      while (bt_s === 1'b1 && n < 600);
    `CHK(n, exp_n)
    `CHK(aux_reg_zero, exp_aux)
  endtask

  task automatic t_loop;
    run(OP_LOAD_AUX_IMMEDIATE, 1'b0, 1'b1, 16'h0000, 16'h0040);
    `CHK(aux_reg_one, 16'h0040)
    loop_from(16'hA003, 4, 16'hA1FF);
    loop_from(16'h01FF, 512, 16'h01FF);
    `CHK(aux_reg_one, 16'h0040)
  endtask

  task automatic t_indirect;
    i_mem.mem[8'h10] = 16'hFFFE;
    i_mem.mem[8'h01] = 16'h0101;
    i_mem.mem[8'h02] = 16'h0202;
    run(OP_LOAD_AUX_IMMEDIATE, 1'b0, 1'b1, 16'h0000, 16'h0010);
    run(OP_LOAD_AUX_POINTER, 1'b0, 1'b1, 16'h0000, 16'h0000);
    `CHK(aux_reg_pointer, 1'b1)
    acc0 = accum;
    run(OP_ADD_INDIRECT_INC, 1'b0, 1'b0, 16'h00AA, 16'h0000);
    `CHK(accum, acc0 + 32'hFFFF_FFFE)
    `CHK(aux_reg_one, 16'h0011)
    `CHK(aux_reg_pointer, 1'b0)
    run(OP_LOAD_AUX_IMMEDIATE, 1'b0, 1'b0, 16'h0000, 16'h0002);
    run(OP_LOAD_MULTIPLICAND, 1'b1, 1'b0, 16'h00AA, 16'h0000);
    `CHK(multiplicand, 16'h0202)
    run(OP_BRANCH_IF_COUNTER_NONZERO, 1'b0, 1'b0, 16'h0000, 16'h0000);
    run(OP_LOAD_MULTIPLICAND, 1'b1, 1'b0, 16'h00AA, 16'h0000);
    `CHK(multiplicand, 16'h0101)
  endtask

  task automatic t_mac;
    i_mem.mem[8'h20] = 16'hFFFD;
    i_mem.mem[8'h21] = 16'h0007;
    run(OP_LOAD_MULTIPLICAND, 1'b0, 1'b0, 16'h0020, 16'h0000);
    `CHK(multiplicand, 16'hFFFD)
    run(OP_MULTIPLY_MEMORY, 1'b0, 1'b0, 16'h0021, 16'h0000);
    `CHK(product, 32'hFFFF_FFEB)
    `CHK(ii_s, 1'b1)
    run(OP_PRODUCT_TO_ACCUM, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(accum, 32'hFFFF_FFEB)
    `CHK(ii_s, 1'b0)
    run(OP_ADD_PRODUCT_TO_ACCUM, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(accum, 32'hFFFF_FFD6)
    run(OP_SUBTRACT_PRODUCT_FROM_ACCUM, 1'b0, 1'b0, 16'h0000, 16'h0000);
    `CHK(accum, 32'hFFFF_FFEB)
    // upper immediate bits set to show they are ignored
    run(OP_MULTIPLY_IMMEDIATE, 1'b0, 1'b0, 16'h0021, 16'h3FFF);
    `CHK(product, 32'h0000_0003)
    run(OP_LOAD_AND_ACCUMULATE, 1'b0, 1'b0, 16'h0021, 16'h0000);
    `CHK(accum, 32'hFFFF_FFEE)
    `CHK(multiplicand, 16'h0007)
    `CHK(product, 32'h0000_0003)
  endtask

  task automatic t_move;
    i_mem.mem[8'h30] = 16'h1234;
    i_mem.mem[8'h32] = 16'h0002;
    run(OP_DATA_SHIFT_MOVE, 1'b0, 1'b0, 16'h0030, 16'h0000);
    `CHK(i_mem.mem[8'h31], 16'h1234)
    `CHK(accum, 32'hFFFF_FFEE)
    // oldest sample first so nothing is overwritten before use
    run(OP_LOAD_MOVE_ACCUMULATE, 1'b0, 1'b0, 16'h0032, 16'h0000);
    run(OP_LOAD_MOVE_ACCUMULATE, 1'b0, 1'b0, 16'h0031, 16'h0000);
    `CHK(i_mem.mem[8'h33], 16'h0002)
    `CHK(i_mem.mem[8'h32], 16'h1234)
    `CHK(multiplicand, 16'h1234)
    `CHK(accum, 32'hFFFF_FFF4)
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    err_total++;
    test_done;
  end

  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst       = 1'b1;
    cmd_valid = 1'b0;
    cmd       = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_loop;
    t_indirect;
    t_mac;
    t_move;
    test_done;
  end
endmodule
